// ===== inc/gpx_pkg.sv
// Constants and helpers shared by the GPIO port with external interrupts
`default_nettype none
package gpx_pkg;
    // ************************************************************
    // Widths
    // ************************************************************
    localparam int PA_W = 8;
    localparam int PB_W = 7;
    localparam int NVEC = 2;
    localparam int VEC_A = 0;
    localparam int VEC_B = 1;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_PA_DATA = 8'h00;
    localparam logic [7:0] OFS_PA_DIR = 8'h01;
    localparam logic [7:0] OFS_PA_OPT = 8'h02;
    localparam logic [7:0] OFS_PB_DATA = 8'h03;
    localparam logic [7:0] OFS_PB_DIR = 8'h04;
    localparam logic [7:0] OFS_PB_OPT = 8'h05;
    localparam logic [7:0] OFS_EDGE_SENS = 8'h06;
    localparam logic [7:0] OFS_SRC_SEL = 8'h07;
    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_PA_DATA = 8'hff;
    localparam logic [7:0] RST_PA_DIR = 8'h00;
    localparam logic [7:0] RST_PA_OPT = 8'h40;
    localparam logic [7:0] RST_PB_DATA = 8'hff;
    localparam logic [7:0] RST_PB_DIR = 8'h00;
    localparam logic [7:0] RST_PB_OPT = 8'h00;
    localparam logic [1:0] RST_EDGE_SENS = 2'h0;
    localparam logic [1:0] RST_SRC_SEL = 2'h0;
    localparam logic [7:0] RD_IDLE = 8'h00;

    // Pad driver enable: open drain releases on a one
    function automatic logic gpx_pad_oe(input logic dir, input logic opt, input logic data);
        return dir & (opt | ~data);
    endfunction : gpx_pad_oe
endpackage : gpx_pkg
`default_nettype wire

// ===== inc/gpx_if.sv
// Interfaces between the port controller, the pin banks and the request latches
`default_nettype none
interface gpx_bank_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic [W-1:0] dir;
    logic [W-1:0] opt;
    logic [W-1:0] read_val;
    logic src_en;
    logic rise_sel;
    logic evt;
    modport ctrl (output data, dir, opt, src_en, rise_sel, input read_val, evt);
    modport bank (input data, dir, opt, src_en, rise_sel, output read_val, evt);
endinterface : gpx_bank_if

interface gpx_irq_if;
    logic [gpx_pkg::NVEC-1:0] evt;
    logic [gpx_pkg::NVEC-1:0] fetch;
    logic [gpx_pkg::NVEC-1:0] pend;
    logic clr_all;
    modport ctrl (output evt, fetch, clr_all, input pend);
    modport latch (input evt, fetch, clr_all, output pend);
endinterface : gpx_irq_if
`default_nettype wire

// ===== hw/gpx_pin_bank.sv
// Pin bank: synchronisers, pad drive, read mux and edge detection
`default_nettype none
module gpx_pin_bank #(parameter int W = 8)
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Configuration and results
    gpx_bank_if.bank bus,
    // Pads
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] pin_pull,
    // Alternate function
    input wire logic [W-1:0] alt_oe,
    input wire logic [W-1:0] alt_out,
    output logic [W-1:0] alt_in
);
    import gpx_pkg::*;

    logic [W-1:0] meta_r, meta_nxt, sync_r, sync_nxt, prev_r, prev_nxt;
    logic [W-1:0] edge_hit;

    // ************************************************************
    // Synchroniser and edge history
    // ************************************************************
    always_comb
    begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    // ************************************************************
    // Per-pin logic
    // ************************************************************
    for (genvar i = 0; i < W; i++)
    begin : g_pin
        // Peripheral output wins over port programming
        assign pin_oe[i] = alt_oe[i] | gpx_pad_oe(bus.dir[i], bus.opt[i], bus.data[i]);
        assign pin_out[i] = alt_oe[i] ? alt_out[i] : bus.data[i];
        assign pin_pull[i] = ~alt_oe[i] & ~bus.dir[i] & bus.opt[i];
        assign bus.read_val[i] = alt_oe[i] ? (bus.dir[i] ? sync_r[i] : alt_out[i])
                                           : (bus.dir[i] ? bus.data[i] : sync_r[i]);
        assign alt_in[i] = bus.dir[i] ? bus.data[i] : sync_r[i];
        assign edge_hit[i] = ~alt_oe[i] & ~bus.dir[i] & bus.opt[i] & bus.src_en
                             & (bus.rise_sel ? (sync_r[i] & ~prev_r[i])
                                             : (~sync_r[i] & prev_r[i]));
    end

    assign bus.evt = |edge_hit;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sync_two_a: assert property (bus.evt |-> $past(pin_in, 2) != $past(pin_in, 3))
        else $error("edge event without a pin change two cycles earlier");
endmodule : gpx_pin_bank
`default_nettype wire

// ===== hw/gpx_irq_latch.sv
// Pending request latches of the external interrupt vectors
`default_nettype none
module gpx_irq_latch
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Events, fetches and pending state
    gpx_irq_if.latch lt
);
    import gpx_pkg::*;

    logic [NVEC-1:0] pend_r, pend_nxt;

    // ************************************************************
    // Set wins over fetch and global clear
    // ************************************************************
    always_comb
    begin
        pend_nxt = lt.evt | (pend_r & ~lt.fetch & ~{NVEC{lt.clr_all}});
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            pend_r <= '0;
        else
            pend_r <= pend_nxt;
    end

    assign lt.pend = pend_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    fetch_clear_a: assert property (lt.fetch[0] && !lt.evt[0] |=> !lt.pend[0])
        else $error("fetch did not clear the pending request");
    set_wins_a: assert property (lt.evt[1] |=> lt.pend[1])
        else $error("event lost");
    pend_hold_a: assert property (lt.pend[0] && !lt.fetch[0] && !lt.clr_all |=> lt.pend[0])
        else $error("pending request dropped without a clear");
endmodule : gpx_irq_latch
`default_nettype wire

// ===== hw/gpx_top.sv
// GPIO ports A and B with external interrupt requests and alternate functions
//
// The address-and-strobe port and the placing of the registers were decided locally.
`default_nettype none
module gpx_top
(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Port A pads
    input wire logic [gpx_pkg::PA_W-1:0] port_a_pins_in,
    output logic [gpx_pkg::PA_W-1:0] port_a_pins_out,
    output logic [gpx_pkg::PA_W-1:0] port_a_pins_oe,
    output logic [gpx_pkg::PA_W-1:0] port_a_pins_pull,
    // Port A alternate functions
    input wire logic [gpx_pkg::PA_W-1:0] pa_alt_oe,
    input wire logic [gpx_pkg::PA_W-1:0] pa_alt_out,
    output logic [gpx_pkg::PA_W-1:0] pa_alt_in,
    // Port B pads
    input wire logic [gpx_pkg::PB_W-1:0] port_b_pins_in,
    output logic [gpx_pkg::PB_W-1:0] port_b_pins_out,
    output logic [gpx_pkg::PB_W-1:0] port_b_pins_oe,
    output logic [gpx_pkg::PB_W-1:0] port_b_pins_pull,
    // Port B alternate functions
    input wire logic [gpx_pkg::PB_W-1:0] pb_alt_oe,
    input wire logic [gpx_pkg::PB_W-1:0] pb_alt_out,
    output logic [gpx_pkg::PB_W-1:0] pb_alt_in,
    // CPU interrupt side
    input wire logic condition_code_reg_i_mask,
    input wire logic [gpx_pkg::NVEC-1:0] vec_fetch,
    output logic [gpx_pkg::NVEC-1:0] ext_irq_req,
    output logic wake_req
);
    import gpx_pkg::*;

    logic [PA_W-1:0] pa_pin_data_latch_r, pa_pin_data_latch_nxt;
    logic [PA_W-1:0] pa_dir_r, pa_dir_nxt, pa_opt_r, pa_opt_nxt;
    logic [PB_W-1:0] pb_pin_data_latch_r, pb_pin_data_latch_nxt;
    logic [PB_W-1:0] pb_dir_r, pb_dir_nxt, pb_opt_r, pb_opt_nxt;
    logic [1:0] edge_sensitivity_control_r, edge_sensitivity_control_nxt;
    logic [1:0] irq_source_select_r, irq_source_select_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    gpx_bank_if #(.W(PA_W)) pa_bus ();
    gpx_bank_if #(.W(PB_W)) pb_bus ();
    gpx_irq_if irq ();

    // ************************************************************
    // Register writes
    // ************************************************************
    always_comb
    begin
        pa_pin_data_latch_nxt = pa_pin_data_latch_r;
        pa_dir_nxt = pa_dir_r;
        pa_opt_nxt = pa_opt_r;
        pb_pin_data_latch_nxt = pb_pin_data_latch_r;
        pb_dir_nxt = pb_dir_r;
        pb_opt_nxt = pb_opt_r;
        edge_sensitivity_control_nxt = edge_sensitivity_control_r;
        irq_source_select_nxt = irq_source_select_r;
        if (reg_wr)
        begin
            unique case (reg_addr)
                OFS_PA_DATA: pa_pin_data_latch_nxt = reg_wdata;
                OFS_PA_DIR: pa_dir_nxt = reg_wdata;
                OFS_PA_OPT: pa_opt_nxt = reg_wdata;
                OFS_PB_DATA: pb_pin_data_latch_nxt = reg_wdata[PB_W-1:0];
                OFS_PB_DIR: pb_dir_nxt = reg_wdata[PB_W-1:0];
                OFS_PB_OPT: pb_opt_nxt = reg_wdata[PB_W-1:0];
                OFS_EDGE_SENS: edge_sensitivity_control_nxt = reg_wdata[1:0];
                OFS_SRC_SEL: irq_source_select_nxt = reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Register reads, data valid one cycle after the strobe
    // ************************************************************
    always_comb
    begin
        rdata_nxt = RD_IDLE;
        if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_PA_DATA: rdata_nxt = pa_bus.read_val;
                OFS_PA_DIR: rdata_nxt = pa_dir_r;
                OFS_PA_OPT: rdata_nxt = pa_opt_r;
                OFS_PB_DATA: rdata_nxt = {1'b0, pb_bus.read_val};
                OFS_PB_DIR: rdata_nxt = {1'b0, pb_dir_r};
                OFS_PB_OPT: rdata_nxt = {1'b0, pb_opt_r};
                OFS_EDGE_SENS: rdata_nxt = {6'h00, edge_sensitivity_control_r};
                OFS_SRC_SEL: rdata_nxt = {6'h00, irq_source_select_r};
                default: rdata_nxt = RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pa_pin_data_latch_r <= RST_PA_DATA;
            pa_dir_r <= RST_PA_DIR;
            pa_opt_r <= RST_PA_OPT;
            pb_pin_data_latch_r <= RST_PB_DATA[PB_W-1:0];
            pb_dir_r <= RST_PB_DIR[PB_W-1:0];
            pb_opt_r <= RST_PB_OPT[PB_W-1:0];
            edge_sensitivity_control_r <= RST_EDGE_SENS;
            irq_source_select_r <= RST_SRC_SEL;
            rdata_r <= RD_IDLE;
        end
        else
        begin
            pa_pin_data_latch_r <= pa_pin_data_latch_nxt;
            pa_dir_r <= pa_dir_nxt;
            pa_opt_r <= pa_opt_nxt;
            pb_pin_data_latch_r <= pb_pin_data_latch_nxt;
            pb_dir_r <= pb_dir_nxt;
            pb_opt_r <= pb_opt_nxt;
            edge_sensitivity_control_r <= edge_sensitivity_control_nxt;
            irq_source_select_r <= irq_source_select_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ************************************************************
    // Pin banks
    // ************************************************************
    assign pa_bus.data = pa_pin_data_latch_r;
    assign pa_bus.dir = pa_dir_r;
    assign pa_bus.opt = pa_opt_r;
    assign pa_bus.src_en = irq_source_select_r[VEC_A];
    assign pa_bus.rise_sel = edge_sensitivity_control_r[VEC_A];
    assign pb_bus.data = pb_pin_data_latch_r;
    assign pb_bus.dir = pb_dir_r;
    assign pb_bus.opt = pb_opt_r;
    assign pb_bus.src_en = irq_source_select_r[VEC_B];
    assign pb_bus.rise_sel = edge_sensitivity_control_r[VEC_B];

    gpx_pin_bank #(.W(PA_W)) u_pa
    (
        .clock(clock),
        .resetn(resetn),
        .bus(pa_bus.bank),
        .pin_in(port_a_pins_in),
        .pin_out(port_a_pins_out),
        .pin_oe(port_a_pins_oe),
        .pin_pull(port_a_pins_pull),
        .alt_oe(pa_alt_oe),
        .alt_out(pa_alt_out),
        .alt_in(pa_alt_in)
    );

    gpx_pin_bank #(.W(PB_W)) u_pb
    (
        .clock(clock),
        .resetn(resetn),
        .bus(pb_bus.bank),
        .pin_in(port_b_pins_in),
        .pin_out(port_b_pins_out),
        .pin_oe(port_b_pins_oe),
        .pin_pull(port_b_pins_pull),
        .alt_oe(pb_alt_oe),
        .alt_out(pb_alt_out),
        .alt_in(pb_alt_in)
    );

    // ************************************************************
    // External interrupt requests
    // ************************************************************
    assign irq.evt = {pb_bus.evt, pa_bus.evt};
    assign irq.fetch = vec_fetch;
    // Only a real change of the selection flushes pending requests
    assign irq.clr_all = reg_wr && (reg_addr == OFS_EDGE_SENS)
                         && (reg_wdata[1:0] != edge_sensitivity_control_r);

    gpx_irq_latch u_irq
    (
        .clock(clock),
        .resetn(resetn),
        .lt(irq.latch)
    );

    // Masked by the CPU's global interrupt bit; also the wake source
    assign ext_irq_req = irq.pend & ~{NVEC{condition_code_reg_i_mask}};
    assign wake_req = |ext_irq_req;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    read_data_a: assert property (reg_rd && reg_addr == OFS_PA_DATA
                                  |=> reg_rdata == $past(pa_bus.read_val))
        else $error("port A data read returned the wrong value");
    read_idle_a: assert property (!reg_rd |=> reg_rdata == RD_IDLE)
        else $error("read data outside the answer cycle");
    input_latch_a: assert property (reg_wr && reg_addr == OFS_PA_DATA && pa_dir_r == 8'h00
                                    && pa_alt_oe == 8'h00
                                    |=> pa_pin_data_latch_r == $past(reg_wdata)
                                        && port_a_pins_oe == 8'h00)
        else $error("input-mode data write disturbed the pad");
    sens_clear_a: assert property (irq.clr_all && irq.evt == 2'h0 |=> irq.pend == 2'h0)
        else $error("edge selection change left a request pending");
    mask_gate_a: assert property (condition_code_reg_i_mask |-> ext_irq_req == 2'h0)
        else $error("request passed a set global mask");
    open_drain_a: assert property (!pa_alt_oe[0] && pa_dir_r[0] && !pa_opt_r[0]
                                   |-> (port_a_pins_oe[0] == !pa_pin_data_latch_r[0])
                                       && (pa_pin_data_latch_r[0] || !port_a_pins_out[0]))
        else $error("open drain drive wrong");
    alt_override_a: assert property (pb_alt_oe[0] |-> port_b_pins_oe[0]
                                     && port_b_pins_out[0] == pb_alt_out[0])
        else $error("peripheral output did not take the pin");
    alt_readback_a: assert property (pa_alt_oe[1] && !pa_dir_r[1]
                                     |-> pa_bus.read_val[1] == pa_alt_out[1])
        else $error("read did not return peripheral output");
    alt_input_a: assert property (pa_dir_r[2] |-> pa_alt_in[2] == pa_pin_data_latch_r[2])
        else $error("peripheral input not fed from the latch");
    sync_path_a: assert property ((!pa_dir_r[3] && !pa_alt_oe[3])[*3]
                                  |-> pa_bus.read_val[3] == $past(port_a_pins_in[3], 2))
        else $error("input read not two cycles behind the pin");
    wake_a: assert property (irq.pend[0] && !condition_code_reg_i_mask |-> wake_req)
        else $error("enabled request did not wake");

    req_seen_c: cover property (ext_irq_req[VEC_A] ##[1:4] vec_fetch[VEC_A]);
    sens_flush_c: cover property (irq.pend != 2'h0 ##1 irq.clr_all);
    back_to_back_c: cover property (reg_wr ##1 reg_rd ##1 reg_rd);
    alt_take_c: cover property (pa_dir_r[0] && pa_alt_oe[0]);
endmodule : gpx_top
`default_nettype wire

// ===== verif/gpx_pin_model.sv
// Pad and board model that resolves each pin's level from all of its drivers
`default_nettype none
module gpx_pin_model #(parameter int W = 8)
(
    // Clock
    input wire logic clock,
    // Pad side of the port
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] pin_pull,
    output logic [W-1:0] pin_in,
    // Board driver controlled by the bench
    input wire logic [W-1:0] ext_val,
    input wire logic [W-1:0] ext_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flt_r = 1'b0;

    // Undriven pin wanders every cycle
    always_ff @(posedge clock)
        flt_r <= ~flt_r;

    // ************************************************************
    // Wire resolution
    // ************************************************************
    always_comb
    begin
        for (int i = 0; i < W; i++)
        begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_en[i])
                pin_in[i] = ext_val[i];
            else if (pin_pull[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = flt_r;
        end
    end
endmodule : gpx_pin_model
`default_nettype wire

// ===== verif/gpx_top_tb_top.sv
// Self-checking testbench of the GPIO port with external interrupt requests
`default_nettype none
module gpx_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import gpx_pkg::*;
    typedef struct packed {
        logic p;
        logic [7:0] dir, opt, data, ext, rd, oe, pull;
    } gpx_tb_row_type;
    logic clock, resetn, reg_wr, reg_rd, mask, wake;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pa_oe, pa_out, pa_pull, pa_in;
    logic [7:0] pa_alt_oe, pa_alt_out, pa_alt_in, a_ext;
    logic [6:0] pb_oe, pb_out, pb_pull, pb_in, pb_alt_oe, pb_alt_out, pb_alt_in, b_ext;
    logic [1:0] fetch, req;
    int err_total, n_compared;
    gpx_tb_row_type rows [6] = '{
        '{1'b0, 8'h00, 8'h00, 8'ha5, 8'h3c, 8'h3c, 8'h00, 8'h00},
        '{1'b0, 8'hff, 8'hff, 8'ha5, 8'h3c, 8'ha5, 8'hff, 8'h00},
        '{1'b0, 8'hff, 8'h00, 8'ha5, 8'h3c, 8'ha5, 8'h5a, 8'h00},
        '{1'b0, 8'h00, 8'hff, 8'ha5, 8'h00, 8'h00, 8'h00, 8'hff},
        '{1'b0, 8'h0f, 8'h33, 8'h96, 8'h5a, 8'h56, 8'h0b, 8'h30},
        '{1'b1, 8'h7f, 8'h7f, 8'hff, 8'h00, 8'h7f, 8'h7f, 8'h00}};

    gpx_top gpx_top_i (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .port_a_pins_in(pa_in), .port_a_pins_out(pa_out), .port_a_pins_oe(pa_oe),
        .port_a_pins_pull(pa_pull), .pa_alt_oe(pa_alt_oe), .pa_alt_out(pa_alt_out),
        .pa_alt_in(pa_alt_in), .port_b_pins_in(pb_in), .port_b_pins_out(pb_out),
        .port_b_pins_oe(pb_oe), .port_b_pins_pull(pb_pull), .pb_alt_oe(pb_alt_oe),
        .pb_alt_out(pb_alt_out), .pb_alt_in(pb_alt_in), .condition_code_reg_i_mask(mask),
        .vec_fetch(fetch), .ext_irq_req(req), .wake_req(wake));
    gpx_pin_model #(.W(8)) gpx_pin_model_a_i (.clock(clock), .pin_out(pa_out),
        .pin_oe(pa_oe), .pin_pull(pa_pull), .pin_in(pa_in), .ext_val(a_ext), .ext_en(8'hff));
    gpx_pin_model #(.W(7)) gpx_pin_model_b_i (.clock(clock), .pin_out(pb_out),
        .pin_oe(pb_oe), .pin_pull(pb_pull), .pin_in(pb_in), .ext_val(b_ext), .ext_en(7'h7f));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ************************************************************
    // Bus and compare helpers
    // ************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    task automatic set_ext(input logic [7:0] a, input logic [6:0] b);
        @(posedge clock);
        a_ext <= a;
        b_ext <= b;
    endtask : set_ext
    task automatic pulse_fetch(input logic [1:0] f);
        @(posedge clock);
        fetch <= f;
        @(posedge clock);
        fetch <= 2'h0;
        #1;
    endtask : pulse_fetch
    // Bounded wait for a pending request, then compare the request lines
    task automatic await_req(input logic [1:0] e);
        int k;
        k = 0;
        while (req !== e && k < 8)
        begin
            cyc(1);
            k++;
        end
        check({6'h0, req}, {6'h0, e});
    endtask : await_req
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (5000) @(posedge clock);
        err_total++;
        conclude();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        logic [7:0] v, base, oe, pull, out;
        {resetn, reg_wr, reg_rd, mask, fetch, reg_addr, reg_wdata} = '0;
        {pa_alt_oe, pa_alt_out, pb_alt_oe, pb_alt_out, a_ext, b_ext} = '0;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        cyc(1);
        check(pa_oe, 8'h00);
        check(pa_pull, 8'h40);
        rd(OFS_EDGE_SENS, v);
        check(v, 8'h00);
        wr(8'h08, 8'h5a);
        rd(8'h08, v);
        check(v, 8'h00);
        // Input latch write stays hidden until the pin turns output
        set_ext(8'hff, 7'h7f);
        wr(OFS_PA_DATA, 8'h00);
        cyc(4);
        rd(OFS_PA_DATA, v);
        check(v, 8'hff);
        wr(OFS_PA_DIR, 8'hff);
        rd(OFS_PA_DATA, v);
        check(v, 8'h00);
        foreach (rows[i])
        begin
            base = rows[i].p ? OFS_PB_DATA : OFS_PA_DATA;
            set_ext(rows[i].ext, rows[i].ext[6:0]);
            wr(base, rows[i].data);
            wr(base + 8'h01, rows[i].dir);
            wr(base + 8'h02, rows[i].opt);
            cyc(4);
            oe = rows[i].p ? {1'b0, pb_oe} : pa_oe;
            pull = rows[i].p ? {1'b0, pb_pull} : pa_pull;
            out = rows[i].p ? {1'b0, pb_out} : pa_out;
            check(oe, rows[i].oe);
            check(pull, rows[i].pull);
            check(out & rows[i].oe, rows[i].data & rows[i].oe);
            check(rows[i].p ? {1'b0, pb_alt_in} : pa_alt_in, rows[i].rd);
            rd(base, v);
            check(v, rows[i].rd);
        end
        // Alternate output overrides input direction and reads back
        wr(OFS_PA_DIR, 8'h00);
        wr(OFS_PA_OPT, 8'h00);
        set_ext(8'h00, 7'h00);
        @(posedge clock);
        pa_alt_oe <= 8'h02;
        pa_alt_out <= 8'h02;
        cyc(4);
        check(pa_oe & 8'h02, 8'h02);
        check(pa_out & 8'h02, 8'h02);
        rd(OFS_PA_DATA, v);
        check(v, 8'h02);
        wr(OFS_PA_DATA, 8'h01);
        wr(OFS_PA_DIR, 8'h01);
        cyc(1);
        check(pa_alt_in & 8'h01, 8'h01);
        @(posedge clock);
        pa_alt_oe <= 8'h00;
        // External interrupts on port A pin 0, rising edge
        wr(OFS_SRC_SEL, 8'h01);
        wr(OFS_EDGE_SENS, 8'h01);
        wr(OFS_PA_DIR, 8'h00);
        wr(OFS_PA_OPT, 8'h01);
        cyc(4);
        set_ext(8'h01, 7'h00);
        await_req(2'h1);
        check({7'h0, wake}, 8'h01);
        pulse_fetch(2'h1);
        check({6'h0, req}, 8'h00);
        set_ext(8'h00, 7'h00);
        cyc(6);
        check({6'h0, req}, 8'h00);
        @(posedge clock);
        mask <= 1'b1;
        set_ext(8'h01, 7'h00);
        cyc(6);
        check({6'h0, req}, 8'h00);
        @(posedge clock);
        mask <= 1'b0;
        cyc(1);
        check({6'h0, req}, 8'h01);
        wr(OFS_EDGE_SENS, 8'h01);
        cyc(1);
        check({6'h0, req}, 8'h01);
        wr(OFS_EDGE_SENS, 8'h03);
        cyc(1);
        check({6'h0, req}, 8'h00);
        // Standard port raises nothing
        wr(OFS_SRC_SEL, 8'h00);
        set_ext(8'h00, 7'h00);
        set_ext(8'h01, 7'h00);
        cyc(6);
        check({6'h0, req}, 8'h00);
        // Port B pin 0 on its own vector, falling edge; a rising pin with the source on raises nothing
        wr(OFS_PB_DIR, 8'h00);
        wr(OFS_PB_OPT, 8'h01);
        wr(OFS_SRC_SEL, 8'h02);
        wr(OFS_EDGE_SENS, 8'h01);
        set_ext(8'h00, 7'h01);
        cyc(4);
        check({6'h0, req}, 8'h00);
        set_ext(8'h00, 7'h00);
        await_req(2'h2);
        pulse_fetch(2'h2);
        check({6'h0, req}, 8'h00);
        conclude();
    end
endmodule : gpx_top_tb_top
`default_nettype wire
